//--- sdt_pkg.sv
// Constants, field layout and types of the split dual 8-bit timer registers
package sdt_pkg;

  // ---------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ---------------------------------------------------------------
  localparam logic [5:0] CTRL_A_IDX    = 6'h00;
  localparam logic [5:0] CTRL_D_IDX    = 6'h03;
  localparam logic [5:0] CMD_CLR_IDX   = 6'h04;
  localparam logic [5:0] CMD_SET_IDX   = 6'h05;
  localparam logic [5:0] INT_EN_IDX    = 6'h0a;
  localparam logic [5:0] INT_FLAG_IDX  = 6'h0b;
  localparam logic [5:0] DBG_CTRL_IDX  = 6'h0e;
  localparam logic [5:0] LOW_COUNTER_VALUE_IDX      = 6'h20;
  localparam logic [5:0] HIGH_COUNTER_VALUE_IDX      = 6'h21;
  localparam logic [5:0] LOW_PERIOD_IDX      = 6'h26;
  localparam logic [5:0] HIGH_PERIOD_IDX      = 6'h27;
  localparam logic [5:0] LCMP_BASE_IDX = 6'h28;
  localparam logic [5:0] LCMP_STEP     = 6'h02;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int unsigned ENABLE_BIT   = 0;
  localparam int unsigned PSEL_LSB     = 1;
  localparam int unsigned SPLIT_BIT    = 0;
  localparam int unsigned TARGET_LSB   = 0;
  localparam int unsigned CMD_LSB      = 2;
  localparam int unsigned LOW_UNDERFLOW_BIT     = 0;
  localparam int unsigned HIGH_UNDERFLOW_BIT     = 1;
  localparam int unsigned LOW_COMPARE_CH0_BIT    = 4;
  localparam int unsigned DBG_RUN_BIT  = 0;

  // ---------------------------------------------------------------
  // Reset values and masks
  // ---------------------------------------------------------------
  localparam logic [7:0] BYTE_RST      = 8'h00;
  localparam logic [7:0] CNT_RST       = 8'h00;
  localparam logic [7:0] PER_RST       = 8'h00;
  localparam logic [7:0] CMP_RST       = 8'h00;
  localparam logic [7:0] IRQ_MASK      = 8'h73;
  localparam int unsigned PRESC_W      = 10;

  localparam logic [1:0] RESP_OKAY     = 2'h0;
  localparam logic [1:0] RESP_SLVERR   = 2'h2;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    CMD_NONE       = 2'h0,
    CMD_RESERVED   = 2'h1,
    CMD_RESTART    = 2'h2,
    CMD_HARD_RESET = 2'h3
  } sdt_cmd_type;

  typedef struct packed {
    logic [2:0] prescale_select;
    logic       enable;
  } sdt_ctrl_type;

  // Prescaler terminal mask for /1 .. /1024
  function automatic logic [PRESC_W-1:0] presc_mask(input logic [2:0] sel);
    unique case (sel)
      3'h0: presc_mask = 10'h000;
      3'h1: presc_mask = 10'h001;
      3'h2: presc_mask = 10'h003;
      3'h3: presc_mask = 10'h007;
      3'h4: presc_mask = 10'h00f;
      3'h5: presc_mask = 10'h03f;
      3'h6: presc_mask = 10'h0ff;
      3'h7: presc_mask = 10'h3ff;
    endcase
  endfunction : presc_mask

endpackage : sdt_pkg

//--- sdt_timer.sv
// Split dual 8-bit down-counter timer with AXI4-Lite register slave
`timescale 1ns/10ps

module sdt_timer
  import sdt_pkg::*;
#(
  parameter int unsigned ADDR_W = 8
) (
  input  wire logic              i_clk,
  input  wire logic              i_nrst,
  input  wire logic [ADDR_W-1:0] i_s_axi_awaddr,
  input  wire logic              i_s_axi_awvalid,
  output logic                   o_s_axi_awready,
  input  wire logic [31:0]       i_s_axi_wdata,
  input  wire logic [3:0]        i_s_axi_wstrb,
  input  wire logic              i_s_axi_wvalid,
  output logic                   o_s_axi_wready,
  output logic [1:0]             o_s_axi_bresp,
  output logic                   o_s_axi_bvalid,
  input  wire logic              i_s_axi_bready,
  input  wire logic [ADDR_W-1:0] i_s_axi_araddr,
  input  wire logic              i_s_axi_arvalid,
  output logic                   o_s_axi_arready,
  output logic [31:0]            o_s_axi_rdata,
  output logic [1:0]             o_s_axi_rresp,
  output logic                   o_s_axi_rvalid,
  input  wire logic              i_s_axi_rready,
  input  wire logic              i_debug_halt,
  output logic [7:0]             o_int_req
);

  initial begin
    if (ADDR_W < 8) begin
      $error("ADDR_W must be at least 8");
    end
  end

  // ---------------------------------------------------------------
  // Decoding helpers
  // ---------------------------------------------------------------
  function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
    logic [5:0] ix;
    ix = a[7:2];
    is_mapped = (a >> 8) == '0 &&
                (ix == CTRL_A_IDX || ix == CTRL_D_IDX || ix == CMD_CLR_IDX ||
                 ix == CMD_SET_IDX || ix == INT_EN_IDX || ix == INT_FLAG_IDX ||
                 ix == DBG_CTRL_IDX || ix == LOW_COUNTER_VALUE_IDX || ix == HIGH_COUNTER_VALUE_IDX ||
                 ix == LOW_PERIOD_IDX || ix == HIGH_PERIOD_IDX ||
                 (ix >= LCMP_BASE_IDX && ix <= LCMP_BASE_IDX + 6'h04 && !ix[0]));
  endfunction : is_mapped

  // ---------------------------------------------------------------
  // AXI4-Lite write channel
  // ---------------------------------------------------------------
  logic              aw_held_q;
  logic [ADDR_W-1:0] aw_addr_q;
  logic              w_held_q;
  logic [31:0]       w_data_q;
  logic              w_lane0_q;
  logic              bvalid_q;
  logic [1:0]        bresp_q;
  logic              wr_fire;
  logic              wr_en;
  logic [5:0]        wr_idx;
  logic [7:0]        wr_byte;

  assign o_s_axi_awready = !aw_held_q;
  assign o_s_axi_wready  = !w_held_q;
  assign o_s_axi_bvalid  = bvalid_q;
  assign o_s_axi_bresp   = bresp_q;
  assign wr_fire = aw_held_q && w_held_q && !bvalid_q;
  assign wr_en   = wr_fire && w_lane0_q && is_mapped(aw_addr_q);
  assign wr_idx  = aw_addr_q[7:2];
  assign wr_byte = w_data_q[7:0];

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      aw_held_q <= 1'b0;
      aw_addr_q <= '0;
    end else if (!aw_held_q && i_s_axi_awvalid) begin
      aw_held_q <= 1'b1;
      aw_addr_q <= i_s_axi_awaddr;
    end else if (wr_fire) begin
      aw_held_q <= 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      w_held_q  <= 1'b0;
      w_data_q  <= '0;
      w_lane0_q <= 1'b0;
    end else if (!w_held_q && i_s_axi_wvalid) begin
      w_held_q  <= 1'b1;
      w_data_q  <= i_s_axi_wdata;
      w_lane0_q <= i_s_axi_wstrb[0];
    end else if (wr_fire) begin
      w_held_q <= 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      bvalid_q <= 1'b0;
      bresp_q  <= RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_q <= 1'b1;
      bresp_q  <= is_mapped(aw_addr_q) ? RESP_OKAY : RESP_SLVERR;
    end else if (i_s_axi_bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Command decode
  // ---------------------------------------------------------------
  sdt_ctrl_type ctrl_q;
  logic         split_q;
  logic [1:0]   target_q;
  logic [7:0]   int_en_q;
  logic [7:0]   flag_q;
  logic         dbg_run_q;
  logic [7:0]   cnt_q [2];
  logic [7:0]   per_q [2];
  logic [7:0]   lcmp_q [3];
  sdt_cmd_type  wr_cmd;
  logic         set_wr;
  logic         restart;
  logic         hard_rst;
  logic         tmr_rst;

  assign set_wr  = wr_en && wr_idx == CMD_SET_IDX;
  assign wr_cmd  = sdt_cmd_type'(wr_byte[CMD_LSB+:2]);
  assign restart = set_wr && wr_cmd == CMD_RESTART;
  assign hard_rst = set_wr && wr_cmd == CMD_HARD_RESET &&
                    wr_byte[TARGET_LSB+:2] == 2'h3 && !ctrl_q.enable;
  assign tmr_rst = !i_nrst || hard_rst;

  // ---------------------------------------------------------------
  // Control registers
  // ---------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (tmr_rst) begin
      ctrl_q <= sdt_ctrl_type'(BYTE_RST[3:0]);
    end else if (wr_en && wr_idx == CTRL_A_IDX) begin
      ctrl_q <= sdt_ctrl_type'(wr_byte[3:0]);
    end
  end

  always_ff @(posedge i_clk) begin
    if (tmr_rst) begin
      split_q <= BYTE_RST[SPLIT_BIT];
    end else if (wr_en && wr_idx == CTRL_D_IDX) begin
      split_q <= wr_byte[SPLIT_BIT];
    end
  end

  always_ff @(posedge i_clk) begin
    if (tmr_rst) begin
      target_q <= BYTE_RST[1:0];
    end else if (wr_en && wr_idx == CMD_CLR_IDX) begin
      target_q <= target_q & ~wr_byte[TARGET_LSB+:2];
    end else if (set_wr) begin
      target_q <= target_q | wr_byte[TARGET_LSB+:2];
    end
  end

  always_ff @(posedge i_clk) begin
    if (tmr_rst) begin
      int_en_q <= BYTE_RST;
      dbg_run_q <= BYTE_RST[DBG_RUN_BIT];
    end else begin
      if (wr_en && wr_idx == INT_EN_IDX) begin
        int_en_q <= wr_byte & IRQ_MASK;
      end
      if (wr_en && wr_idx == DBG_CTRL_IDX) begin
        dbg_run_q <= wr_byte[DBG_RUN_BIT];
      end
    end
  end

  // ---------------------------------------------------------------
  // Prescaler and run gating
  // ---------------------------------------------------------------
  logic [PRESC_W-1:0] presc_q;
  logic [PRESC_W-1:0] mask;
  logic               run;
  logic               tick;
  assign run  = ctrl_q.enable && split_q && (dbg_run_q || !i_debug_halt);
  assign mask = presc_mask(ctrl_q.prescale_select);
  assign tick = run && (presc_q & mask) == mask;

  always_ff @(posedge i_clk) begin
    if (tmr_rst || restart) begin
      presc_q <= '0;
    end else if (run) begin
      presc_q <= presc_q + 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // Counters and periods
  // ---------------------------------------------------------------
  logic [1:0] cnt_wr;
  logic [1:0] unf_evt;
  for (genvar i = 0; i < 2; i++) begin : g_cnt
    localparam logic [5:0] CIDX = (i == 0) ? LOW_COUNTER_VALUE_IDX : HIGH_COUNTER_VALUE_IDX;
    localparam logic [5:0] PIDX = (i == 0) ? LOW_PERIOD_IDX : HIGH_PERIOD_IDX;
    assign cnt_wr[i]  = wr_en && wr_idx == CIDX;
    assign unf_evt[i] = tick && cnt_q[i] == 8'h00 && !cnt_wr[i] &&
                        !(restart && wr_byte[TARGET_LSB+i]);

    always_ff @(posedge i_clk) begin
      if (tmr_rst) begin
        cnt_q[i] <= CNT_RST;
      end else if (cnt_wr[i]) begin
        cnt_q[i] <= wr_byte;
      end else if (restart && wr_byte[TARGET_LSB+i]) begin
        cnt_q[i] <= per_q[i];
      end else if (tick) begin
        cnt_q[i] <= (cnt_q[i] == 8'h00) ? per_q[i] : cnt_q[i] - 8'h01;
      end
    end

    always_ff @(posedge i_clk) begin
      if (tmr_rst) begin
        per_q[i] <= PER_RST;
      end else if (wr_en && wr_idx == PIDX) begin
        per_q[i] <= wr_byte;
      end
    end
  end

  // ---------------------------------------------------------------
  // Low compare registers and match
  // ---------------------------------------------------------------
  logic [2:0] cmp_hit;
  for (genvar n = 0; n < 3; n++) begin : g_cmp
    localparam logic [5:0] MIDX = LCMP_BASE_IDX + LCMP_STEP * 6'(n);
    assign cmp_hit[n] = run && cnt_q[0] == lcmp_q[n];

    always_ff @(posedge i_clk) begin
      if (tmr_rst) begin
        lcmp_q[n] <= CMP_RST;
      end else if (wr_en && wr_idx == MIDX) begin
        lcmp_q[n] <= wr_byte;
      end
    end
  end

  // ---------------------------------------------------------------
  // Flags and interrupt requests
  // ---------------------------------------------------------------
  logic [7:0] flag_set;
  logic [7:0] flag_clr;
  always_comb begin
    flag_set = '0;
    flag_set[LOW_UNDERFLOW_BIT] = unf_evt[0];
    flag_set[HIGH_UNDERFLOW_BIT] = unf_evt[1];
    flag_set[LOW_COMPARE_CH0_BIT+:3] = cmp_hit;
    flag_clr = (wr_en && wr_idx == INT_FLAG_IDX) ? (wr_byte & IRQ_MASK) : 8'h00;
  end

  always_ff @(posedge i_clk) begin
    if (tmr_rst) begin
      flag_q <= BYTE_RST;
    end else begin
      flag_q <= (flag_q & ~flag_clr) | flag_set;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      o_int_req <= BYTE_RST;
    end else begin
      o_int_req <= flag_q & int_en_q;
    end
  end

  // ---------------------------------------------------------------
  // AXI4-Lite read channel
  // ---------------------------------------------------------------
  logic [7:0] rd_byte;
  logic [5:0] rd_idx;
  logic       rvalid_q;
  assign rd_idx          = i_s_axi_araddr[7:2];
  assign o_s_axi_arready = !rvalid_q;
  assign o_s_axi_rvalid  = rvalid_q;

  always_comb begin
    rd_byte = 8'h00;
    unique case (rd_idx)
      CTRL_A_IDX:   rd_byte = {4'h0, ctrl_q};
      CTRL_D_IDX:   rd_byte = {7'h00, split_q};
      CMD_CLR_IDX,
      CMD_SET_IDX:  rd_byte = {6'h00, target_q};
      INT_EN_IDX:   rd_byte = int_en_q;
      INT_FLAG_IDX: rd_byte = flag_q;
      DBG_CTRL_IDX: rd_byte = {7'h00, dbg_run_q};
      LOW_COUNTER_VALUE_IDX:     rd_byte = cnt_q[0];
      HIGH_COUNTER_VALUE_IDX:     rd_byte = cnt_q[1];
      LOW_PERIOD_IDX:     rd_byte = per_q[0];
      HIGH_PERIOD_IDX:     rd_byte = per_q[1];
      LCMP_BASE_IDX:                         rd_byte = lcmp_q[0];
      LCMP_BASE_IDX + LCMP_STEP:             rd_byte = lcmp_q[1];
      LCMP_BASE_IDX + LCMP_STEP + LCMP_STEP: rd_byte = lcmp_q[2];
      default:      rd_byte = 8'h00;
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (!i_nrst) begin
      rvalid_q      <= 1'b0;
      o_s_axi_rdata <= '0;
      o_s_axi_rresp <= RESP_OKAY;
    end else if (!rvalid_q && i_s_axi_arvalid) begin
      rvalid_q      <= 1'b1;
      o_s_axi_rdata <= is_mapped(i_s_axi_araddr) ? {24'h000000, rd_byte} : 32'h00000000;
      o_s_axi_rresp <= is_mapped(i_s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
    end else if (i_s_axi_rready) begin
      rvalid_q <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);
  property p_cmd_reads_zero;
    (!rvalid_q && i_s_axi_arvalid && (rd_idx == CMD_SET_IDX || rd_idx == CMD_CLR_IDX))
      |=> o_s_axi_rdata[3:2] == 2'h0;
  endproperty
  a_cmd_reads_zero: assert property (p_cmd_reads_zero) else $error("command field read nonzero");
  property p_clr_alias;
    (wr_en && wr_idx == CMD_CLR_IDX) |=> target_q == ($past(target_q) & ~$past(wr_byte[1:0]));
  endproperty
  a_clr_alias: assert property (p_clr_alias) else $error("clear alias wrong");
  property p_set_alias;
    (set_wr && !hard_rst) |=> target_q == ($past(target_q) | $past(wr_byte[1:0]));
  endproperty
  a_set_alias: assert property (p_set_alias) else $error("set alias wrong");
  property p_hard_ignored;
    (set_wr && wr_cmd == CMD_HARD_RESET && ctrl_q.enable) |=> ctrl_q.enable;
  endproperty
  a_hard_ignored: assert property (p_hard_ignored) else $error("hard reset while enabled");
  property p_cnt_priority;
    (cnt_wr[0] && tick) |=> cnt_q[0] == $past(wr_byte);
  endproperty
  a_cnt_priority: assert property (p_cnt_priority) else $error("count beat counter write");
  property p_cpu_wins;
    cnt_wr[1] |=> cnt_q[1] == $past(wr_byte);
  endproperty
  a_cpu_wins: assert property (p_cpu_wins) else $error("counter write lost");
  property p_halt;
    (!run && !cnt_wr[0] && !restart && !hard_rst) |=> $stable(cnt_q[0]);
  endproperty
  a_halt: assert property (p_halt) else $error("counter moved while halted");
  property p_unf_flag;
    unf_evt[1] |=> flag_q[HIGH_UNDERFLOW_BIT] ##1 (flag_q[HIGH_UNDERFLOW_BIT] || $past(flag_clr[HIGH_UNDERFLOW_BIT]));
  endproperty
  a_unf_flag: assert property (p_unf_flag) else $error("high underflow flag missing");
  property p_cmp_sticky;
    (flag_q[LOW_COMPARE_CH0_BIT] && !flag_clr[LOW_COMPARE_CH0_BIT] && !hard_rst) |=> flag_q[LOW_COMPARE_CH0_BIT];
  endproperty
  a_cmp_sticky: assert property (p_cmp_sticky) else $error("compare flag cleared");
  property p_irq;
    (flag_q[LOW_UNDERFLOW_BIT] && int_en_q[LOW_UNDERFLOW_BIT]) |=> o_int_req[LOW_UNDERFLOW_BIT];
  endproperty
  a_irq: assert property (p_irq) else $error("low underflow request missing");

endmodule : sdt_timer

//--- sdt_timer_test.sv
// Self-checking register-level bench for the split dual 8-bit timer
`timescale 1ns/10ps

module sdt_timer_test
  import sdt_pkg::*;
();
  // ---------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------
  logic        clk;
  logic        nrst;
  logic [7:0]  awaddr;
  logic [7:0]  araddr;
  logic        awvalid;
  logic        wvalid;
  logic        arvalid;
  logic        bready;
  logic        rready;
  logic        dbg_halt;
  logic [31:0] wdata;
  logic [3:0]  wstrb;
  logic        awready;
  logic        wready;
  logic        bvalid;
  logic        arready;
  logic        rvalid;
  logic [1:0]  bresp;
  logic [1:0]  rresp;
  logic [31:0] rdata;
  logic [7:0]  int_req;
  int          failures;
  int          samples_checked;
  int          cyc;
  int          eff;
  int          nrun;
  logic [5:0]  rst_idx [9] = '{CMD_CLR_IDX, CMD_SET_IDX, INT_EN_IDX, INT_FLAG_IDX,
                              DBG_CTRL_IDX, LOW_COUNTER_VALUE_IDX, HIGH_COUNTER_VALUE_IDX, LOW_PERIOD_IDX, HIGH_PERIOD_IDX};
  int          shift [8] = '{0, 1, 2, 3, 4, 6, 8, 10};

  sdt_timer #(.ADDR_W(8)) dut_u (
    .i_clk           (clk),
    .i_nrst          (nrst),
    .i_s_axi_awaddr  (awaddr),
    .i_s_axi_awvalid (awvalid),
    .o_s_axi_awready (awready),
    .i_s_axi_wdata   (wdata),
    .i_s_axi_wstrb   (wstrb),
    .i_s_axi_wvalid  (wvalid),
    .o_s_axi_wready  (wready),
    .o_s_axi_bresp   (bresp),
    .o_s_axi_bvalid  (bvalid),
    .i_s_axi_bready  (bready),
    .i_s_axi_araddr  (araddr),
    .i_s_axi_arvalid (arvalid),
    .o_s_axi_arready (arready),
    .o_s_axi_rdata   (rdata),
    .o_s_axi_rresp   (rresp),
    .o_s_axi_rvalid  (rvalid),
    .i_s_axi_rready  (rready),
    .i_debug_halt    (dbg_halt),
    .o_int_req       (int_req)
  );

  always #12.5 clk = ~clk;
  always @(posedge clk) cyc <= cyc + 1;

  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic conclude;
    if (failures == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : conclude

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic tmo(input int n);
    if (n >= 64) begin
      failures++;
      conclude();
    end
  endtask : tmo

  // Write one byte; effect edge index left in eff
  task automatic wr(input logic [5:0] idx, input logic [7:0] val, input logic [1:0] er = RESP_OKAY);
    int   n;
    logic aw_p;
    logic w_p;
    aw_p = 1'b1;
    w_p = 1'b1;
    awaddr <= {idx, 2'h0};
    wdata <= {24'h0, val};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    for (n = 0; n < 64 && (aw_p || w_p); n++) begin
      @(negedge clk);
      if (awready) aw_p = 1'b0;
      if (wready) w_p = 1'b0;
      @(posedge clk);
      if (!aw_p) awvalid <= 1'b0;
      if (!w_p) wvalid <= 1'b0;
    end
    tmo(n);
    for (n = 0; n < 64; n++) begin
      @(negedge clk);
      if (bvalid) break;
    end
    tmo(n);
    eff = cyc;
    check("bresp", 32'(bresp), 32'(er));
    @(posedge clk);
  endtask : wr

  task automatic rd_raw(input logic [5:0] idx, output logic [31:0] d, output logic [1:0] r);
    int n;
    araddr <= {idx, 2'h0};
    arvalid <= 1'b1;
    for (n = 0; n < 64; n++) begin
      @(negedge clk);
      if (arready) break;
    end
    tmo(n);
    @(posedge clk);
    arvalid <= 1'b0;
    for (n = 0; n < 64; n++) begin
      @(negedge clk);
      if (rvalid) break;
    end
    tmo(n);
    d = rdata;
    r = rresp;
    @(posedge clk);
  endtask : rd_raw

  task automatic rd(input logic [5:0] idx, input logic [7:0] exp, input string name,
                    input logic [1:0] er = RESP_OKAY);
    logic [31:0] d;
    logic [1:0]  r;
    rd_raw(idx, d, r);
    check(name, d, {24'h0, exp});
    check("rresp", 32'(r), 32'(er));
  endtask : rd

  // Enable for a while, then disable; running edges left in nrun
  task automatic run(input logic [2:0] ps, input int cycles);
    int e1;
    wr(CTRL_A_IDX, {4'h0, ps, 1'b1});
    e1 = eff;
    repeat (cycles) @(posedge clk);
    wr(CTRL_A_IDX, {4'h0, ps, 1'b0});
    nrun = eff - e1;
  endtask : run

  task automatic rst_all;
    foreach (rst_idx[i]) rd(rst_idx[i], 8'h00, "reset value");
  endtask : rst_all

  // Down-count model: underflow flag above the count
  function automatic logic [8:0] dn(input logic [7:0] c, input logic [7:0] p, input int n);
    logic uf;
    uf = 1'b0;
    for (int i = 0; i < n; i++) begin
      if (c == 8'h00) begin
        c = p;
        uf = 1'b1;
      end else begin
        c = c - 8'h01;
      end
    end
    return {uf, c};
  endfunction : dn

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    logic [31:0] v;
    logic [1:0]  r;
    logic        ul;
    logic        uh;
    logic [7:0]  el;
    logic [7:0]  eh;
    logic [7:0]  fl;
    int          d;
    int          t;
    clk = 1'b0;
    nrst = 1'b0;
    awaddr = 8'h00;
    araddr = 8'h00;
    awvalid = 1'b0;
    wvalid = 1'b0;
    arvalid = 1'b0;
    bready = 1'b1;
    rready = 1'b1;
    dbg_halt = 1'b0;
    wdata = 32'h0;
    wstrb = 4'h1;
    failures = 0;
    samples_checked = 0;
    cyc = 0;
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    rst_all();
    wr(6'h06, 8'hff, RESP_SLVERR);
    rd(6'h06, 8'h00, "unmapped", RESP_SLVERR);
    wr(CMD_SET_IDX, 8'h01);
    rd(CMD_SET_IDX, 8'h01, "target set low");
    wr(CMD_SET_IDX, 8'h06);
    rd(CMD_SET_IDX, 8'h03, "target set high");
    wr(CMD_CLR_IDX, 8'h0d);
    rd(CMD_CLR_IDX, 8'h02, "target clear low");
    wr(CMD_CLR_IDX, 8'h02);
    rd(CMD_SET_IDX, 8'h00, "target clear high");
    // Split off: no counting
    wr(LOW_COUNTER_VALUE_IDX, 8'h40);
    run(3'h0, 30);
    rd(LOW_COUNTER_VALUE_IDX, 8'h40, "count without split");
    wr(CTRL_D_IDX, 8'h01);
    wr(LOW_PERIOD_IDX, 8'hff);
    wr(HIGH_PERIOD_IDX, 8'hff);
    for (int k = 0; k < 8; k++) begin
      wr(LOW_COUNTER_VALUE_IDX, 8'hf0);
      wr(HIGH_COUNTER_VALUE_IDX, 8'hf0);
      run(k[2:0], (k < 5) ? 60 : 1100);
      rd_raw(LOW_COUNTER_VALUE_IDX, v, r);
      d = 240 - int'(v[7:0]);
      t = nrun >> shift[k];
      check("prescaled ticks", 32'(d >= t - 1 && d <= t + 1), 32'h1);
      rd(HIGH_COUNTER_VALUE_IDX, v[7:0], "high prescaled count");
    end
    wr(LOW_PERIOD_IDX, 8'h03);
    wr(HIGH_PERIOD_IDX, 8'h05);
    wstrb <= 4'h0;
    wr(LOW_PERIOD_IDX, 8'h77);
    wstrb <= 4'h1;
    rd(LOW_PERIOD_IDX, 8'h03, "strobe off write");
    wr(LCMP_BASE_IDX, 8'h01);
    wr(LCMP_BASE_IDX + LCMP_STEP, 8'h07);
    wr(LCMP_BASE_IDX + LCMP_STEP + LCMP_STEP, 8'h02);
    wr(INT_FLAG_IDX, 8'hff);
    wr(INT_EN_IDX, 8'hff);
    rd(INT_EN_IDX, 8'h73, "interrupt enable");
    wr(LOW_COUNTER_VALUE_IDX, 8'h02);
    wr(HIGH_COUNTER_VALUE_IDX, 8'h01);
    run(3'h0, 20);
    {ul, el} = dn(8'h02, 8'h03, nrun);
    {uh, eh} = dn(8'h01, 8'h05, nrun);
    fl = {4'h5, 2'h0, uh, ul};
    rd(LOW_COUNTER_VALUE_IDX, el, "low count");
    rd(HIGH_COUNTER_VALUE_IDX, eh, "high count");
    rd(INT_FLAG_IDX, fl, "flags");
    @(negedge clk);
    check("request all", 32'(int_req), 32'(fl));
    wr(INT_EN_IDX, 8'h01);
    @(posedge clk);
    @(negedge clk);
    check("request masked", 32'(int_req), 32'(fl & 8'h01));
    wr(INT_FLAG_IDX, 8'h10);
    rd(INT_FLAG_IDX, fl & 8'hef, "compare clear");
    wr(INT_FLAG_IDX, 8'h00);
    rd(INT_FLAG_IDX, fl & 8'hef, "write zero");
    wr(INT_FLAG_IDX, 8'h02);
    rd(INT_FLAG_IDX, fl & 8'hed, "high clear");
    dbg_halt <= 1'b1;
    for (int i = 1; i >= 0; i--) begin
      wr(DBG_CTRL_IDX, 8'(i));
      rd(DBG_CTRL_IDX, 8'(i), "debug run");
      wr(LOW_COUNTER_VALUE_IDX, 8'h80);
      run(3'h0, 20);
      rd(LOW_COUNTER_VALUE_IDX, (i == 1) ? 8'h80 - 8'(nrun) : 8'h80, "debug count");
    end
    wr(CTRL_A_IDX, 8'h01);
    wr(CMD_SET_IDX, 8'h0f);
    rd(LOW_PERIOD_IDX, 8'h03, "reset while enabled");
    wr(CTRL_A_IDX, 8'h00);
    dbg_halt <= 1'b0;
    wr(CMD_SET_IDX, 8'h0d);
    rd(LOW_PERIOD_IDX, 8'h03, "reset needs both");
    wr(LOW_COUNTER_VALUE_IDX, 8'h20);
    wr(HIGH_COUNTER_VALUE_IDX, 8'h21);
    wr(CMD_SET_IDX, 8'h09);
    rd(LOW_COUNTER_VALUE_IDX, 8'h03, "restart low");
    rd(HIGH_COUNTER_VALUE_IDX, 8'h21, "restart low only");
    wr(CMD_SET_IDX, 8'h0a);
    rd(HIGH_COUNTER_VALUE_IDX, 8'h05, "restart high");
    wr(LOW_PERIOD_IDX, 8'hff);
    wr(CTRL_A_IDX, 8'h01);
    wr(LOW_COUNTER_VALUE_IDX, 8'h55);
    t = eff;
    repeat (10) @(posedge clk);
    wr(CTRL_A_IDX, 8'h00);
    rd(LOW_COUNTER_VALUE_IDX, 8'h55 - 8'(eff - t), "write beats count");
    wr(CMD_SET_IDX, 8'h0f);
    rst_all();
    rd(CTRL_D_IDX, 8'h00, "split after reset");
    conclude();
  end
endmodule : sdt_timer_test
